/* pkg/spi_ctl_regs.vh */
// register map, field positions, reset values and divider counts for the spi controller
// assumes inclusion from a plain verilog-2005 design file
`ifndef SPI_CTL_REGS_VH
`define SPI_CTL_REGS_VH
// word indices; byte address is four times the index
`define IDX_CTRL_A        3'h0
`define IDX_CTRL_B        3'h1
`define IDX_INT_EN        3'h2
`define IDX_INT_FLAGS     3'h3
`define IDX_DATA          3'h4
`define ADDR_LSB          2
// control a fields
`define CA_ORDER          6
`define CA_MASTER         5
`define CA_DOUBLE         4
`define CA_CLOCK_DIVIDER_SELECT_HI       2
`define CA_CLOCK_DIVIDER_SELECT_LO       1
`define CA_ENABLE         0
// control b fields
`define CB_BUFFERED_OPERATION_ENABLE          7
`define CB_BUFFER_WAIT_FOR_RECEIVE          6
`define CB_SSD            2
`define CB_MODE_HI        1
`define CB_MODE_LO        0
// interrupt enable / flag fields
`define F_RXC             7
`define F_TXC             6
`define F_DRE             5
`define F_SSI             4
`define F_OVF             0
`define RESET_BYTE        8'h00
// synchroniser idle: select high, clock and data low
`define SYNC_IDLE         4'h8
// half-period counts of the serial clock, in pclk cycles, per prescaler value
`define HALF_DIV4         7'h02
`define HALF_DIV16        7'h08
`define HALF_DIV64        7'h20
`define HALF_DIV128       7'h40
`define BITS_PER_BYTE     4'h8
`endif

/* hw/spi_ctl.v */
// spi peripheral control: prescaler, clock modes, select handling, buffering, flags
// assumes apb3 master on pclk; spi pins come from outside and are synchronised here
// Notes on behaviour
// RULE1 - master clock from pclk divided by 4, 16, 64 or 128 per prescaler.
// RULE2 - prescaler setting has no effect while acting as slave.
// RULE3 - clock double bit doubles the prescaled serial clock rate.
// RULE4 - buffered mode gives two receive buffers, one transmit buffer, split flags.
// RULE5 - wait-for-receive zero: first byte after a write is a dummy.
// RULE6 - wait-for-receive one: write while enabled and select high loads shifter.
// RULE7 - select disable in master mode ignores the select input.
// RULE8 - mode field picks leading edge polarity and sample or setup edge.
// RULE9 - idle clock low for rising leading edge, high for falling.
// RULE10 - four split enables work only buffered, read zero otherwise.
// RULE11 - non-buffered single enable raises request when shared flag set.
// RULE12 - buffered receive flag tracks unread receive data.
// RULE13 - receive flag clears on data read or on writing one.
// RULE14 - shared flag sets on byte done or on select low in master.
// RULE15 - shared flag clears on vector ack or flags read then data access.
// RULE16 - buffered transfer flag sets when shifter and buffer empty; write one clears.
// RULE17 - write collision flag sets on data write mid-byte; same clear as shared. Code clears it only on flags read then data access, not on vector ack.
// RULE18 - empty flag one when transmit buffer empty, zero non-buffered.
// RULE19 - data write clears empty flag; flag resets to zero.
// RULE20 - buffered select trigger flag sets on external select low in master.
// RULE21 - select low in master clears master bit and sets shared flag.
// RULE22 - data write starts sending; buffered read pops second receive buffer.
// RULE23 - buffered overflow on third byte with both receive buffers full.
// RULE24 - enable zero stops transfers and serial clock.
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "spi_ctl_regs.vh"

module spi_ctl (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        irq_ack,
  output reg         irq,
  input  wire        sck_in,
  output reg         sck_out,
  output reg         sck_oe,
  input  wire        mosi_in,
  output reg         mosi_out,
  output reg         mosi_oe,
  input  wire        miso_in,
  output reg         miso_out,
  output reg         miso_oe,
  input  wire        ss_n_in,
  input  wire        ss_is_input
);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  reg  [3:0] sync1_q;
  reg  [3:0] sync2_q;

  // two flops on the select, clock, mosi and miso inputs
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_q <= `SYNC_IDLE;                          // both stages alike: no false edge
      sync2_q <= `SYNC_IDLE;
    end
    else
    begin
      sync1_q <= {ss_n_in, sck_in, mosi_in, miso_in};
      sync2_q <= sync1_q;
    end
  end

  wire ss_n_s = sync2_q[3];
  wire sck_s  = sync2_q[2];
  wire mosi_s = sync2_q[1];
  wire miso_s = sync2_q[0];

  // ------------------------------------------------------------
  // registers and state
  // ------------------------------------------------------------
  reg  [7:0] ctrl_a_q;
  reg  [7:0] ctrl_b_q;
  reg  [7:0] int_en_q;
  reg        rxc_q, txc_q, dre_q, ssi_q, ovf_q;
  reg        done_q, wcol_q, armed_q;
  reg  [7:0] tx_buf_q, shift_q, rx1_q, rx2_q;
  reg        tx_full_q, rx1_v_q, rx2_v_q, shift_ld_q;
  reg        busy_q, phase_q, sck_prev_q, dummy_q;
  reg  [3:0] bits_q;
  reg  [6:0] div_q;

  wire enable  = ctrl_a_q[`CA_ENABLE];
  wire master  = ctrl_a_q[`CA_MASTER];
  wire buffered_operation_enable   = ctrl_b_q[`CB_BUFFERED_OPERATION_ENABLE];
  wire lsb1st  = ctrl_a_q[`CA_ORDER];
  wire cpol    = ctrl_b_q[`CB_MODE_HI];               // RULE8
  wire cpha    = ctrl_b_q[`CB_MODE_LO];               // RULE8

  wire wr_en   = psel && penable && pwrite;
  wire rd_en   = psel && penable && !pwrite;
  wire [2:0] idx = paddr[`ADDR_LSB+2:`ADDR_LSB];
  wire mapped  = (paddr[`ADDR_LSB-1:0] == 2'h0) && (paddr[7:`ADDR_LSB+3] == 3'h0)
                 && (idx <= `IDX_DATA);
  wire data_wr = wr_en && mapped && idx == `IDX_DATA;
  wire data_rd = rd_en && mapped && idx == `IDX_DATA;
  wire flag_wr = wr_en && mapped && idx == `IDX_INT_FLAGS;
  wire flag_rd = rd_en && mapped && idx == `IDX_INT_FLAGS;

  // select fault: input select pulled low while master and not disabled
  wire ss_fault = enable && master && ss_is_input && !ss_n_s
                  && !ctrl_b_q[`CB_SSD];              // RULE7

  // ------------------------------------------------------------
  // master clock divider
  // ------------------------------------------------------------
  reg [6:0] half_lim;

  // half period from prescaler, halved again on clock double
  always @*
  begin
    case (ctrl_a_q[`CA_CLOCK_DIVIDER_SELECT_HI:`CA_CLOCK_DIVIDER_SELECT_LO])        // RULE1
      2'h0:    half_lim = `HALF_DIV4;
      2'h1:    half_lim = `HALF_DIV16;
      2'h2:    half_lim = `HALF_DIV64;
      default: half_lim = `HALF_DIV128;
    endcase
    if (ctrl_a_q[`CA_DOUBLE])
      half_lim = {1'b0, half_lim[6:1]};               // RULE3
  end

  wire tick = master && busy_q && (div_q == half_lim - 7'h01); // RULE2

  // slave edges from the synchronised serial clock
  wire s_edge  = !master && busy_q && (sck_s != sck_prev_q);
  wire edge_ev = tick || s_edge;
  wire lead    = !phase_q;                            // leading edge of a bit
  wire samp_ev = edge_ev && (lead ^ cpha);            // RULE8
  wire last    = edge_ev && phase_q && (bits_q == `BITS_PER_BYTE - 4'h1);
  wire in_bit  = master ? miso_s : mosi_s;
  wire [7:0] shift_in = lsb1st ? {in_bit, shift_q[7:1]} : {shift_q[6:0], in_bit};
  // byte ends on a trailing edge; only odd modes still sample there
  wire [7:0] rx_word  = samp_ev ? shift_in : shift_q;
  wire start_m = master && !busy_q && shift_ld_q;
  wire start_s = !master && !busy_q && !ss_n_s;

  // ------------------------------------------------------------
  // shift engine
  // ------------------------------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      busy_q     <= 1'b0;
      phase_q    <= 1'b0;
      bits_q     <= 4'h0;
      div_q      <= 7'h00;
      sck_prev_q <= 1'b0;
      sck_out    <= 1'b0;
    end
    else
    begin
      sck_prev_q <= sck_s;
      if (!enable || ss_fault)                        // RULE24
      begin
        busy_q  <= 1'b0;
        phase_q <= 1'b0;
        bits_q  <= 4'h0;
        div_q   <= 7'h00;
        sck_out <= cpol;                              // RULE9
      end
      else if (start_m || start_s)                    // RULE22
      begin
        busy_q  <= 1'b1;
        sck_out <= cpol;
      end
      else if (busy_q)
      begin
        div_q <= tick ? 7'h00 : div_q + 7'h01;
        if (edge_ev)
        begin
          phase_q <= !phase_q;
          if (master)
            sck_out <= phase_q ? cpol : !cpol;
          if (phase_q)
            bits_q <= bits_q + 4'h1;
          if (last)
          begin
            busy_q <= 1'b0;
            bits_q <= 4'h0;
          end
        end
        if (!master && ss_n_s)
        begin
          busy_q <= 1'b0;
          bits_q <= 4'h0;
        end
      end
      else
        sck_out <= cpol;                              // RULE9
    end
  end

  // ------------------------------------------------------------
  // data path, buffers and flags
  // ------------------------------------------------------------
  wire tx_load = !busy_q && !shift_ld_q && tx_full_q && !dummy_q;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_a_q <= `RESET_BYTE;
      ctrl_b_q <= `RESET_BYTE;
      int_en_q <= `RESET_BYTE;
      {rxc_q, txc_q, dre_q, ssi_q, ovf_q} <= 5'h00;   // RULE19
      {done_q, wcol_q, armed_q} <= 3'h0;
      tx_buf_q <= `RESET_BYTE;
      shift_q  <= `RESET_BYTE;
      rx1_q    <= `RESET_BYTE;
      rx2_q    <= `RESET_BYTE;
      {tx_full_q, rx1_v_q, rx2_v_q, shift_ld_q, dummy_q} <= 5'h00;
    end
    else
    begin
      // register writes
      if (wr_en && mapped && idx == `IDX_CTRL_A)
        ctrl_a_q <= pwdata[7:0] & 8'h77;
      if (wr_en && mapped && idx == `IDX_CTRL_B)
      begin
        ctrl_b_q <= pwdata[7:0] & 8'hc7;
        dummy_q  <= pwdata[`CB_BUFFERED_OPERATION_ENABLE] && !pwdata[`CB_BUFFER_WAIT_FOR_RECEIVE]; // RULE5
      end
      if (wr_en && mapped && idx == `IDX_INT_EN)
        int_en_q <= pwdata[7:0] & 8'hf1;
      // write-one clears, sets below win
      if (flag_wr && buffered_operation_enable)
      begin
        if (pwdata[`F_RXC]) rxc_q <= 1'b0;            // RULE13
        if (pwdata[`F_TXC]) txc_q <= 1'b0;            // RULE16
        if (pwdata[`F_SSI]) ssi_q <= 1'b0;            // RULE20
      end
      // arm the read-then-access clear
      if (flag_rd && (done_q || wcol_q))
        armed_q <= 1'b1;
      if ((data_rd || data_wr) && armed_q)            // RULE15
      begin
        done_q  <= 1'b0;
        wcol_q  <= 1'b0;                              // RULE17
        armed_q <= 1'b0;
      end
      if (irq_ack && !buffered_operation_enable)
        done_q <= 1'b0;                               // RULE15
      // data write
      if (data_wr)
      begin
        if (!buffered_operation_enable)
        begin
          if (busy_q) wcol_q <= 1'b1;                 // RULE17
          else
          begin
            shift_q    <= pwdata[7:0];                // RULE22
            shift_ld_q <= 1'b1;
          end
        end
        else if (!tx_full_q)
        begin
          if (ctrl_b_q[`CB_BUFFER_WAIT_FOR_RECEIVE] && enable && ss_n_s && !busy_q && !shift_ld_q)
          begin
            shift_q    <= pwdata[7:0];                // RULE6
            shift_ld_q <= 1'b1;
          end
          else
          begin
            tx_buf_q  <= pwdata[7:0];
            tx_full_q <= 1'b1;
          end
          dre_q <= 1'b0;                              // RULE19
          txc_q <= 1'b0;
        end
      end
      // buffered pop: second buffer read, first moves in
      if (data_rd && buffered_operation_enable)
      begin
        rx2_q   <= rx1_q;                             // RULE22
        rx2_v_q <= rx1_v_q;
        rx1_v_q <= 1'b0;
        ovf_q   <= 1'b0;
        if (!rx1_v_q) rxc_q <= 1'b0;                  // RULE12
      end
      // move buffered byte into the shifter
      if (tx_load && buffered_operation_enable)
      begin
        shift_q    <= tx_buf_q;
        shift_ld_q <= 1'b1;
        tx_full_q  <= 1'b0;
        dre_q      <= 1'b1;                           // RULE18
      end
      if (start_m || start_s)
        shift_ld_q <= 1'b0;
      if (samp_ev)
        shift_q <= shift_in;
      // end of byte
      if (last)
      begin
        dummy_q <= 1'b0;                              // RULE5
        if (!buffered_operation_enable)
          done_q <= 1'b1;                             // RULE14
        else
        begin
          rxc_q <= 1'b1;                              // RULE12
          if (!tx_full_q) txc_q <= 1'b1;              // RULE16
          if (!rx2_v_q || (data_rd && !rx1_v_q))
          begin
            rx2_q   <= rx_word;
            rx2_v_q <= 1'b1;
          end
          else if (!rx1_v_q || data_rd)               // RULE4
          begin
            rx1_q   <= rx_word;
            rx1_v_q <= 1'b1;
          end
          else
            ovf_q <= 1'b1;                            // RULE23
        end
      end
      else if (!buffered_operation_enable)
        rx2_q <= rx2_q;
      if (last && !buffered_operation_enable)
        rx2_q <= rx_word;
      // select fault drops to slave
      if (ss_fault)
      begin
        ctrl_a_q[`CA_MASTER] <= 1'b0;                 // RULE21
        if (buffered_operation_enable) ssi_q <= 1'b1;                     // RULE20
        else done_q <= 1'b1;                          // RULE14
      end
      // buffered mode (re)entered: transmit buffer empty
      if (buffered_operation_enable && !tx_full_q && !dre_q && !data_wr && dummy_q == 1'b0 && !busy_q)
        dre_q <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // read mux and apb answer
  // ------------------------------------------------------------
  reg [7:0] rd_byte;
  wire [7:0] en_view = buffered_operation_enable ? int_en_q : (int_en_q & 8'h01);      // RULE10
  wire [7:0] flag_view = buffered_operation_enable
    ? {rxc_q, txc_q, dre_q, ssi_q, 3'h0, ovf_q}
    : {done_q, wcol_q, 6'h00};                        // RULE18

  // select the addressed register
  always @*
  begin
    case (idx)
      `IDX_CTRL_A:    rd_byte = ctrl_a_q;
      `IDX_CTRL_B:    rd_byte = ctrl_b_q;
      `IDX_INT_EN:    rd_byte = en_view;
      `IDX_INT_FLAGS: rd_byte = flag_view;
      `IDX_DATA:      rd_byte = buffered_operation_enable ? rx2_q : rx2_q;
      default:        rd_byte = `RESET_BYTE;
    endcase
  end

  // registered answer, no wait state; unmapped gives pslverr
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata  <= (psel && !penable && mapped && !pwrite) ? {24'h000000, rd_byte} : 32'h0;
    end
  end

  // ------------------------------------------------------------
  // interrupt request and pin drivers
  // ------------------------------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq      <= 1'b0;
      sck_oe   <= 1'b0;
      mosi_out <= 1'b0;
      mosi_oe  <= 1'b0;
      miso_out <= 1'b0;
      miso_oe  <= 1'b0;
    end
    else
    begin
      irq <= buffered_operation_enable ? |(en_view[7:4] & flag_view[7:4])                // RULE10
                   : (int_en_q[`F_OVF] && done_q);                   // RULE11
      sck_oe   <= enable && master;                                  // RULE24
      mosi_oe  <= enable && master;
      miso_oe  <= enable && !master && !ss_n_s;
      mosi_out <= lsb1st ? shift_q[0] : shift_q[7];
      miso_out <= lsb1st ? shift_q[0] : shift_q[7];
    end
  end

endmodule // spi_ctl
`default_nettype wire

/* test/spi_ctl_chk.sv */
// checker for the spi controller bus answer, request line and clock pins
// assumes binding onto spi_ctl; shadows a few register bits from bus writes
`timescale 1ns/1ps
`default_nettype none
module spi_ctl_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq,
  input wire logic        sck_out,
  input wire logic        sck_oe,
  input wire logic        ss_n_in,
  input wire logic        ss_is_input
);
  logic       wr;
  logic       en_q;
  logic       ssd_q;
  logic       cpol_q;
  logic [7:0] ien_q;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----
  // shadow of enable, select disable, clock polarity and irq enables
  // ----
  assign wr = psel && penable && pready && pwrite && !pslverr;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      en_q  <= 1'b0;
      ssd_q <= 1'b0;
      cpol_q <= 1'b0;
      ien_q <= 8'h00;
    end
    else if (wr)
    begin
      if (paddr == 8'h00) en_q <= pwdata[0];
      if (paddr == 8'h04) ssd_q <= pwdata[2];
      if (paddr == 8'h04) cpol_q <= pwdata[1];
      if (paddr == 8'h08) ien_q <= pwdata[7:0];
    end
  end
  pready_answer_a: assert property (psel && !penable |=> pready)
    else $error("no answer one cycle after setup");
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  slverr_pair_a: assert property (pslverr |-> pready && psel && penable)
    else $error("error without answer");
  rdata_quiet_a: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
    else $error("read data outside read answer");
  unmapped_err_a: assert property (psel && !penable && (paddr > 8'h10 || paddr[1:0] != 2'h0)
    |=> pslverr) else $error("unmapped access not refused");
  disabled_sck_a: assert property (!en_q && !$past(en_q) |-> sck_out == $past(cpol_q))
    else $error("serial clock moves while disabled");
  irq_masked_a: assert property (ien_q == 8'h00 && $past(ien_q) == 8'h00 |-> !irq)
    else $error("request with all enables off");
  select_drop_a: assert property (en_q && !ssd_q && ss_is_input && !ss_n_in [*6]
    |-> !sck_oe) else $error("still driving clock after select low");
endmodule // spi_ctl_chk
bind spi_ctl spi_ctl_chk i_chk (.*);
`default_nettype wire

/* test/spi_peer.sv */
// spi slave peer: shifts one byte out and in per eight clock cycles
// assumes the controller is master; select and mode come from the bench
`timescale 1ns/1ps
`default_nettype none
module spi_peer (
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       sel_n,
  input  wire logic [1:0] mode,
  input  wire logic [7:0] tx_byte,
  output logic            miso,
  output logic [7:0]      rx_byte
);
  logic [7:0] sh;
  logic [3:0] cnt;
  logic       last = 1'b0;
  logic       samp_rise;
  // sample on rising edge for modes 0 and 3
  assign samp_rise = (mode == 2'h0) || (mode == 2'h3);
  // released line shows the inverse of the last bit
  assign miso = sel_n ? ~last : sh[7];
  always @(negedge sel_n)
  begin
    sh  <= tx_byte;
    cnt <= mode[0] ? 4'h8 : 4'h0;
  end
  always @(posedge sel_n)
    last <= sh[7];
  // sample edge shifts in, setup edge shifts out or reloads
  always @(sck)
  begin
    if (!sel_n && sck == samp_rise)
    begin
      rx_byte <= {rx_byte[6:0], mosi};
      cnt     <= cnt + 4'h1;
    end
    else if (!sel_n && cnt == 4'h8)
    begin
      sh  <= tx_byte;
      cnt <= 4'h0;
    end
    else if (!sel_n)
      sh <= {sh[6:0], 1'b0};
  end
endmodule // spi_peer
`default_nettype wire

/* test/spi_control_and_flags_test.sv */
// self-checking bench for the spi controller with a slave peer model
// assumes spi_ctl, spi_peer and the bound checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module spi_control_and_flags_test;
  localparam logic [7:0] ad_ca = 8'h00, ad_cb = 8'h04, ad_ie = 8'h08;
  localparam logic [7:0] ad_fl = 8'h0c, ad_dt = 8'h10;
  logic        pclk, presetn, psel, penable, pwrite, irq_ack, ss_n_in, ss_is_input, sel_n;
  logic        pready, pslverr, irq, sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe;
  logic        miso, er;
  logic [7:0]  paddr, tx_byte, rx_byte;
  logic [1:0]  mode;
  logic [31:0] pwdata, prdata, r;
  int          error_cnt, samples_checked;
  int          dv[4] = '{4, 16, 64, 128};
  spi_ctl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq_ack(irq_ack), .irq(irq), .sck_in(1'b0), .sck_out(sck_out),
    .sck_oe(sck_oe), .mosi_in(1'b0), .mosi_out(mosi_out), .mosi_oe(mosi_oe),
    .miso_in(miso), .miso_out(miso_out), .miso_oe(miso_oe), .ss_n_in(ss_n_in),
    .ss_is_input(ss_is_input));
  spi_peer i_peer (.sck(sck_out), .mosi(mosi_out), .sel_n(sel_n), .mode(mode),
    .tx_byte(tx_byte), .miso(miso), .rx_byte(rx_byte));
  // ----
  // bus and compare tasks
  // ----
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      error_cnt++;
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic wt(input int b);
    do rd(ad_fl); while (r[b] !== 1'b1);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_regs;
    rd(ad_cb); chk("ctrl_b reset", r, 32'h0);
    rd(ad_ie); chk("enables reset", r, 32'h0);
    rd(ad_fl); chk("flags reset", r, 32'h0);
    wr(ad_cb, 8'hc7); rd(ad_cb); chk("ctrl_b rw", r, 32'hc7);
    wr(ad_cb, 8'h00);
    wr(ad_ie, 8'hf1); rd(ad_ie); chk("enables unbuffered", r, 32'h01);
    rd(8'h14); chk("unmapped err", {31'h0, er}, 32'h1);
    chk("unmapped data", r, 32'h0);
    $display("test regs done");
  endtask
  task automatic t_modes;
    for (int m = 0; m < 4; m++)
    begin
      mode = m[1:0];
      wr(ad_cb, {6'h0, m[1:0]});
      wr(ad_ca, 8'h23); // divide by 16: room for the synchronised miso path
      repeat (8) @(posedge pclk);
      chk("idle sck", sck_out, m[1]);
      tx_byte = 8'h3c + m[7:0];
      sel_n = 1'b0;
      wr(ad_dt, 8'h96 ^ m[7:0]); wt(7);
      rd(ad_dt); chk("rx data", r, 8'h3c + m[7:0]);
      chk("peer data", rx_byte, 8'h96 ^ m[7:0]);
      sel_n = 1'b1;
    end
    mode = 2'h0;
    wr(ad_cb, 8'h00);
    $display("test modes done");
  endtask
  task automatic t_div;
    realtime t0;
    sel_n = 1'b0;
    for (int p = 0; p < 4; p++)
      for (int d = 0; d < 2; d++)
      begin
        wr(ad_ca, {3'b001, d[0], 1'b0, p[1:0], 1'b1});
        wr(ad_dt, 8'h55);
        @(posedge sck_out);
        t0 = $realtime;
        @(posedge sck_out);
        chk("sck period", int'(($realtime - t0) / 4.0), dv[p] >> d);
        wt(7); rd(ad_dt);
      end
    $display("test divider done");
  endtask
  task automatic t_irq;
    int n;
    wr(ad_ca, 8'h21); wr(ad_ie, 8'h01); wr(ad_dt, 8'h11);
    for (n = 0; n < 2000 && irq !== 1'b1; n++) @(posedge pclk);
    chk("irq raised", irq, 1'b1);
    irq_ack <= 1'b1;
    @(posedge pclk);
    irq_ack <= 1'b0;
    rd(ad_fl); chk("ack clears", r[7], 1'b0);
    chk("irq cleared", irq, 1'b0);
    wr(ad_ie, 8'h00);
    $display("test irq done");
  endtask
  task automatic t_wcol;
    wr(ad_dt, 8'h01); wr(ad_dt, 8'h02);
    rd(ad_fl); chk("collision", r[6], 1'b1);
    wt(7); rd(ad_dt);
    rd(ad_fl); chk("flags cleared", r[7:6], 2'h0);
    $display("test collision done");
  endtask
  task automatic t_sel;
    sel_n = 1'b1;
    wr(ad_cb, 8'h04); ss_n_in <= 1'b0;
    repeat (8) @(posedge pclk);
    rd(ad_ca); chk("master kept", r[5], 1'b1);
    ss_n_in <= 1'b1;
    wr(ad_cb, 8'h00); ss_n_in <= 1'b0;
    repeat (8) @(posedge pclk);
    rd(ad_ca); chk("master dropped", r[5], 1'b0);
    rd(ad_fl); chk("drop flag", r[7], 1'b1);
    rd(ad_dt); ss_n_in <= 1'b1;
    wr(ad_cb, 8'h80); wr(ad_ca, 8'h21); ss_n_in <= 1'b0;
    repeat (8) @(posedge pclk);
    rd(ad_fl); chk("select trigger", r[4], 1'b1);
    wr(ad_fl, 8'h10); rd(ad_fl); chk("trigger cleared", r[4], 1'b0);
    ss_n_in <= 1'b1;
    $display("test select done");
  endtask
  task automatic t_buf;
    wr(ad_cb, 8'hc0); wr(ad_ca, 8'h23);
    tx_byte = 8'h5a;
    sel_n = 1'b0;
    wr(ad_dt, 8'h43); wr(ad_dt, 8'h44);
    rd(ad_fl); chk("buffer held", r[5], 1'b0);
    tx_byte = 8'ha5; // peer reloads this at the end of the first byte
    wt(6);
    rd(ad_fl); chk("buffered flags", r[7:5], 3'h7);
    chk("peer second", rx_byte, 8'h44);
    wr(ad_fl, 8'h40); rd(ad_fl); chk("txc cleared", r[6], 1'b0);
    rd(ad_dt); chk("first rx", r, 32'h5a);
    rd(ad_dt); chk("second rx", r, 32'ha5);
    rd(ad_fl); chk("rx empty", r[7], 1'b0);
    wr(ad_ie, 8'hf1); rd(ad_ie); chk("enables buffered", r, 32'hf1);
    wr(ad_ie, 8'h00);
    sel_n = 1'b1;
    $display("test buffered done");
  endtask
  // ----
  // clock, reset, sequence and watchdog
  // ----
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  initial
  begin
    {presetn, psel, penable, pwrite, irq_ack} = 5'h0;
    {paddr, pwdata, tx_byte, mode} = '0;
    {ss_n_in, ss_is_input, sel_n} = 3'h7;
    error_cnt = 0;
    samples_checked = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_modes;
    t_div;
    t_irq;
    t_wcol;
    t_sel;
    t_buf;
    print_verdict;
  end
  initial
  begin
    repeat (40000) @(posedge pclk);
    error_cnt++;
    print_verdict;
  end
endmodule // spi_control_and_flags_test
`default_nettype wire
